// file: common/adcd_pkg.sv
package adcd_pkg;

    // sample word
    localparam int unsigned ADCD_CODE_W = 8;
    localparam logic [7:0] ADCD_CODE_MAX = 8'hFF;
    localparam logic [7:0] ADCD_CODE_MIN = 8'h00;

    // analog input as signed millivolts
    localparam int unsigned ADCD_AIN_W = 16;

    // full-scale spans in mV, peak to peak
    localparam logic [11:0] ADCD_SPAN_LO = 12'h258;
    localparam logic [11:0] ADCD_SPAN_HI = 12'h320;
    // half spans in mV, out-of-range limits
    localparam logic [11:0] ADCD_HALF_LO = 12'h12C;
    localparam logic [11:0] ADCD_HALF_HI = 12'h190;
    // code scale, 2^24 / span, rounded down
    localparam logic [15:0] ADCD_SCALE_LO = 16'h6D3A;
    localparam logic [15:0] ADCD_SCALE_HI = 16'h51EB;

    // pipeline depth for the paired outputs
    localparam int unsigned ADCD_PIPE_D = 8;
    localparam int unsigned ADCD_LAT_FIRST = 8;
    localparam int unsigned ADCD_LAT_SECOND = 7;

    // calibration request qualifier, in sample clocks
    localparam logic [3:0] ADCD_CAL_REQ_MIN = 4'hA;

    // power-up waits and calibration length, in sample clocks
    localparam int unsigned ADCD_CNT_W = 24;
    localparam int unsigned ADCD_WAIT_SHORT_DEF = 32'h0000_0400;
    localparam int unsigned ADCD_WAIT_LONG_DEF = 32'h0000_4000;
    localparam int unsigned ADCD_CAL_LEN_DEF = 32'h0000_0800;

    // settle cycles before the delay-select strap is caught
    localparam logic [1:0] ADCD_STRAP_SETTLE = 2'h3;

    // register byte offsets
    localparam logic [7:0] ADCD_OFS_STATUS = 8'h00;
    localparam logic [7:0] ADCD_OFS_MASK = 8'h04;
    localparam logic [7:0] ADCD_OFS_STATE = 8'h08;
    localparam logic [7:0] ADCD_OFS_CTRL = 8'h0C;

    // event bits of status and mask
    localparam int unsigned ADCD_EV_W = 4;
    localparam int unsigned ADCD_EV_CAL_DONE = 0;
    localparam int unsigned ADCD_EV_CAL_START = 1;
    localparam int unsigned ADCD_EV_OOR = 2;
    localparam int unsigned ADCD_EV_PAIR = 3;
    localparam logic [3:0] ADCD_MASK_RST = 4'h0;

    // control bits
    localparam int unsigned ADCD_CTRL_CAL = 0;

    typedef enum logic [3:0] {
        ADCD_ST_WAIT = 4'b0001,
        ADCD_ST_RUN = 4'b0010,
        ADCD_ST_CAL = 4'b0100,
        ADCD_ST_PDN = 4'b1000
    } adcd_state_e;

endpackage : adcd_pkg

// file: verilog/adcd_core.sv
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
// How it works
// R1: a sample is taken on each falling edge of the sample clock
// R2: each result is an 8-bit offset binary code, zeros at most negative
// R3: samples alternate onto two buses, each updating at half sample rate
// R4: earlier sample of a pair goes to first bus, later to second
// R5: latency is eight sample clocks on first bus, seven on second
// R6: edge select high, data changes on forwarded clock rise; low, on fall
// R7: both buses change only in step with the forwarded data clock
// R8: power down high stops conversion; low allows normal operation
// R9: calibration starts after ten clocks request low then ten clocks high
// R10: after power up, wait the selected count, then calibrate
// R11: delay select low gives short wait, high gives longer wait
// R12: calibration running is high for the whole of any calibration
// R13: full-scale select low maps 600 mV span, high maps 800 mV span
// R14: out of range flags inputs beyond 300 mV or 400 mV half span
module adcd_core
    import adcd_pkg::*;
#(
    parameter int unsigned WAIT_SHORT = ADCD_WAIT_SHORT_DEF,
    parameter int unsigned WAIT_LONG = ADCD_WAIT_LONG_DEF,
    parameter int unsigned CAL_LEN = ADCD_CAL_LEN_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic sample_clk_i,
    input wire logic [15:0] analog_in_i,
    input wire logic output_edge_select_i,
    input wire logic power_down_pin_i,
    input wire logic calibration_request_i,
    input wire logic calibration_delay_select_i,
    input wire logic full_scale_select_i,
    output logic [7:0] first_sample_bus_o,
    output logic [7:0] second_sample_bus_o,
    output logic output_data_clock_o,
    output logic out_of_range_o,
    output logic calibration_running_o
);

    // pin synchronisers
    logic [5:0] pin_m_r;
    logic [5:0] pin_s_r;
    logic [15:0] ain_m_r;
    logic [15:0] ain_s_r;
    logic sclk_d_r;
    logic samp_ev;
    logic sclk_s;
    logic edge_s;
    logic cal_s;
    logic pd_s;
    logic fsr_s;
    logic dly_s;

    // control state
    adcd_state_e state_r;
    logic [1:0] settle_r;
    logic strap_ok_r;
    logic dly_sel_r;
    logic [ADCD_CNT_W-1:0] cnt_r;
    logic [ADCD_CNT_W-1:0] wait_end;
    logic [3:0] lo_cnt_r;
    logic [3:0] hi_cnt_r;
    logic req_trig;
    logic sw_cal;
    logic cal_go;
    logic auto_go;
    logic cal_end;
    logic conv_en;

    // data path
    logic [7:0] pipe_r [ADCD_PIPE_D];
    logic [7:0] code;
    logic oor;
    logic [17:0] shifted;
    logic [32:0] prod;
    logic [11:0] span;
    logic [15:0] scale;
    logic output_data_clock_r;
    logic upd;

    // bus side
    logic acc;
    logic rd_status;
    logic [ADCD_EV_W-1:0] status_r;
    logic [ADCD_EV_W-1:0] mask_r;
    logic [ADCD_EV_W-1:0] ev;

    always_ff @(posedge clk_i) begin
        pin_m_r <= {calibration_delay_select_i, full_scale_select_i,
            power_down_pin_i, calibration_request_i,
            output_edge_select_i, sample_clk_i};
        pin_s_r <= pin_m_r;
        ain_m_r <= analog_in_i;
        ain_s_r <= ain_m_r;
    end

    assign sclk_s = pin_s_r[0];
    assign edge_s = pin_s_r[1];
    assign cal_s = pin_s_r[2];
    assign pd_s = pin_s_r[3];
    assign fsr_s = pin_s_r[4];
    assign dly_s = pin_s_r[5];

    // falling edge of the sample clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
        end
    end

    assign samp_ev = sclk_d_r & ~sclk_s; // R1

    // delay-select strap caught once the synchroniser has settled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_r <= 2'h0;
            strap_ok_r <= 1'b0;
            dly_sel_r <= 1'b0;
        end else if (!strap_ok_r) begin
            if (settle_r == ADCD_STRAP_SETTLE) begin
                strap_ok_r <= 1'b1;
                dly_sel_r <= dly_s;
            end else begin
                settle_r <= settle_r + 2'h1;
            end
        end
    end

    assign wait_end = dly_sel_r ? ADCD_CNT_W'(WAIT_LONG - 1) :
        ADCD_CNT_W'(WAIT_SHORT - 1); // R11

    // calibration request qualifier
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lo_cnt_r <= 4'h0;
            hi_cnt_r <= 4'h0;
        end else if (samp_ev) begin
            if (!cal_s) begin
                hi_cnt_r <= 4'h0;
                if (lo_cnt_r != ADCD_CAL_REQ_MIN) begin
                    lo_cnt_r <= lo_cnt_r + 4'h1;
                end
            end else if (lo_cnt_r == ADCD_CAL_REQ_MIN) begin
                if (req_trig) begin
                    lo_cnt_r <= 4'h0;
                    hi_cnt_r <= 4'h0;
                end else begin
                    hi_cnt_r <= hi_cnt_r + 4'h1;
                end
            end else begin
                lo_cnt_r <= 4'h0;
            end
        end
    end

    assign req_trig = samp_ev & cal_s & (lo_cnt_r == ADCD_CAL_REQ_MIN) &
        (hi_cnt_r == ADCD_CAL_REQ_MIN - 4'h1); // R9

    assign sw_cal = acc & wb_we_i & wb_sel_i[0] &
        (wb_adr_i == ADCD_OFS_CTRL) & wb_dat_i[ADCD_CTRL_CAL];
    assign cal_go = (state_r == ADCD_ST_RUN) & (req_trig | sw_cal);
    assign cal_end = (state_r == ADCD_ST_CAL) & samp_ev &
        (cnt_r == ADCD_CNT_W'(CAL_LEN - 1));
    assign auto_go = (state_r == ADCD_ST_WAIT) & strap_ok_r & samp_ev &
        (cnt_r == wait_end) & ~pd_s; // R10

    // main sequencer, counts run on sample clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ADCD_ST_WAIT;
            cnt_r <= '0;
        end else if (pd_s && state_r != ADCD_ST_PDN) begin
            state_r <= ADCD_ST_PDN; // R8
            cnt_r <= '0;
        end else begin
            unique case (state_r)
                ADCD_ST_WAIT: begin
                    if (strap_ok_r && samp_ev) begin
                        if (cnt_r == wait_end) begin
                            state_r <= ADCD_ST_CAL; // R10
                            cnt_r <= '0;
                        end else begin
                            cnt_r <= cnt_r + 1'b1;
                        end
                    end
                end
                ADCD_ST_RUN: begin
                    if (cal_go) begin
                        state_r <= ADCD_ST_CAL; // R9
                        cnt_r <= '0;
                    end
                end
                ADCD_ST_CAL: begin
                    if (cal_end) begin
                        state_r <= ADCD_ST_RUN;
                        cnt_r <= '0;
                    end else if (samp_ev) begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ADCD_ST_PDN: begin
                    if (!pd_s) begin
                        state_r <= ADCD_ST_RUN; // R8
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            calibration_running_o <= 1'b0;
        end else begin
            calibration_running_o <= (state_r == ADCD_ST_WAIT) ? auto_go :
                (state_r == ADCD_ST_CAL) ? ~cal_end & ~pd_s :
                (state_r == ADCD_ST_RUN) ? cal_go & ~pd_s : 1'b0; // R12
        end
    end

    assign conv_en = (state_r == ADCD_ST_RUN) & samp_ev;

    // quantiser: offset binary over the selected span
    always_comb begin
        span = fsr_s ? ADCD_SPAN_HI : ADCD_SPAN_LO; // R13
        scale = fsr_s ? ADCD_SCALE_HI : ADCD_SCALE_LO; // R13
        shifted = {{2{ain_s_r[15]}}, ain_s_r} +
            {6'h00, (fsr_s ? ADCD_HALF_HI : ADCD_HALF_LO)};
        prod = shifted[16:0] * scale;
        oor = shifted[17] | (shifted[16:0] > {5'h00, span}); // R14
        if (shifted[17]) begin
            code = ADCD_CODE_MIN; // R2
        end else if (prod[32:24] != 9'h000) begin
            code = ADCD_CODE_MAX; // R2
        end else begin
            code = prod[23:16]; // R2
        end
    end

    // sample pipeline
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < ADCD_PIPE_D; i++) begin
                pipe_r[i] <= ADCD_CODE_MIN;
            end
        end else if (conv_en) begin
            pipe_r[0] <= code; // R1
            for (int i = 1; i < ADCD_PIPE_D; i++) begin
                pipe_r[i] <= pipe_r[i-1];
            end
        end
    end

    // forwarded clock toggles each sample, data moves on the chosen edge
    assign upd = conv_en & ((~output_data_clock_r) == edge_s); // R6

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_data_clock_r <= 1'b0;
        end else if (conv_en) begin
            output_data_clock_r <= ~output_data_clock_r; // R7
        end
    end

    assign output_data_clock_o = output_data_clock_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_sample_bus_o <= ADCD_CODE_MIN;
            second_sample_bus_o <= ADCD_CODE_MIN;
        end else if (upd) begin
            first_sample_bus_o <= pipe_r[ADCD_LAT_FIRST-1]; // R3 R4 R5
            second_sample_bus_o <= pipe_r[ADCD_LAT_SECOND-1]; // R3 R4 R5
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_of_range_o <= 1'b0;
        end else if (conv_en) begin
            out_of_range_o <= oor; // R14
        end
    end

    // wishbone slave, one wait state
    assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign rd_status = acc & ~wb_we_i & (wb_adr_i == ADCD_OFS_STATUS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (acc && !wb_we_i) begin
            unique case (wb_adr_i)
                ADCD_OFS_STATUS: wb_dat_o <= {28'h0000000, status_r};
                ADCD_OFS_MASK: wb_dat_o <= {28'h0000000, mask_r};
                ADCD_OFS_STATE: wb_dat_o <= {24'h000000, state_r,
                    dly_sel_r, output_data_clock_r, out_of_range_o,
                    calibration_running_o};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= ADCD_MASK_RST;
        end else if (acc && wb_we_i && wb_sel_i[0] &&
            wb_adr_i == ADCD_OFS_MASK) begin
            mask_r <= wb_dat_i[ADCD_EV_W-1:0];
        end
    end

    // sticky events, set wins over the read clear
    always_comb begin
        ev = '0;
        ev[ADCD_EV_CAL_DONE] = cal_end;
        ev[ADCD_EV_CAL_START] = cal_go | auto_go;
        ev[ADCD_EV_OOR] = conv_en & oor;
        ev[ADCD_EV_PAIR] = upd;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= '0;
        end else begin
            status_r <= (rd_status ? '0 : status_r) | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_r & mask_r);
        end
    end

endmodule : adcd_core

// file: bench/adcd_props.sv
`timescale 1ns/1ps
module adcd_props
    import adcd_pkg::*;
#(
    parameter int unsigned CAL_LEN = ADCD_CAL_LEN_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic irq_o,
    input wire logic output_edge_select_i,
    input wire logic power_down_pin_i,
    input wire logic [7:0] first_sample_bus_o,
    input wire logic [7:0] second_sample_bus_o,
    input wire logic output_data_clock_o,
    input wire logic out_of_range_o,
    input wire logic calibration_running_o
);
    localparam int CAL_MIN = CAL_LEN * 8 - 8;
    localparam int CAL_MAX = CAL_LEN * 8 + 16;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    first_edge_a: assert property ($changed(first_sample_bus_o) |->
        $changed(output_data_clock_o) &&
        output_data_clock_o == output_edge_select_i)
        else $error("first bus moved off the chosen clock edge");
    second_edge_a: assert property ($changed(second_sample_bus_o) |->
        $changed(output_data_clock_o) &&
        output_data_clock_o == output_edge_select_i)
        else $error("second bus moved off the chosen clock edge");
    output_data_clock_rate_a: assert property ($changed(output_data_clock_o) |=>
        $stable(output_data_clock_o)[*6])
        else $error("data clock faster than half sample rate");
    pd_freeze_a: assert property (power_down_pin_i[*6] |=>
        $stable(output_data_clock_o) && !calibration_running_o)
        else $error("conversion went on in power down");
    cal_hold_a: assert property (
        $rose(calibration_running_o) && !power_down_pin_i |=>
        calibration_running_o[*8])
        else $error("calibration flag dropped early");
    cal_len_a: assert property ($rose(calibration_running_o) |->
        ##[CAL_MIN:CAL_MAX] !calibration_running_o)
        else $error("calibration length out of bounds");
    oor_sync_a: assert property ($changed(out_of_range_o) |->
        $changed(output_data_clock_o))
        else $error("range flag moved without a converted sample");
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
        wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    cal_c: cover property ($rose(calibration_running_o));
    irq_c: cover property ($rose(irq_o));
    oor_c: cover property ($rose(out_of_range_o));
endmodule : adcd_props

bind adcd_core adcd_props #(.CAL_LEN(CAL_LEN)) i_adcd_props (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq_o,
    .output_edge_select_i, .power_down_pin_i, .first_sample_bus_o,
    .second_sample_bus_o, .output_data_clock_o, .out_of_range_o,
    .calibration_running_o
);

// file: bench/adcd_capture.sv
`timescale 1ns/1ps
module adcd_capture (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic output_edge_select_i,
    input wire logic output_data_clock_i,
    input wire logic [7:0] first_sample_bus_i,
    input wire logic [7:0] second_sample_bus_i,
    output logic [15:0] pair_o,
    output logic [15:0] count_o
);
    logic output_data_clock_d_r;
    always_ff @(posedge clk_i) begin
        output_data_clock_d_r <= output_data_clock_i;
        if (rst_i) begin
            count_o <= 16'h0000;
            pair_o <= 16'h0000;
        end else if (output_data_clock_i != output_data_clock_d_r &&
            output_data_clock_i != output_edge_select_i) begin
            pair_o <= {first_sample_bus_i, second_sample_bus_i};
            count_o <= count_o + 16'h0001;
        end
    end
endmodule : adcd_capture

// file: bench/tb.sv
`timescale 1ns/1ps
module tb
    import adcd_pkg::*;
;
    logic clk_i = 0, rst_i = 1, sample_clk_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic wb_we_i = 0, output_edge_select_i = 0, power_down_pin_i = 0;
    logic calibration_request_i = 1, calibration_delay_select_i = 0;
    logic full_scale_select_i = 0, wb_ack_o, irq_o, output_data_clock_o;
    logic out_of_range_o, calibration_running_o;
    logic [7:0] wb_adr_i = 8'h00, first_sample_bus_o, second_sample_bus_o;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [15:0] analog_in_i = 16'h0, pair, cnt, cnt_d = 16'h0, c;
    logic sc_d = 0, chk_on = 0, oor_seen = 0, cal_seen = 0;
    int idx = 0, hit, last = -1, n, failures = 0, checks = 0;

    adcd_core #(.WAIT_SHORT(4), .WAIT_LONG(8), .CAL_LEN(6)) i_adcd_core (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .sample_clk_i, .analog_in_i,
        .output_edge_select_i, .power_down_pin_i, .calibration_request_i,
        .calibration_delay_select_i, .full_scale_select_i,
        .first_sample_bus_o, .second_sample_bus_o, .output_data_clock_o,
        .out_of_range_o, .calibration_running_o);
    adcd_capture i_adcd_capture (.clk_i, .rst_i, .output_edge_select_i,
        .output_data_clock_i(output_data_clock_o),
        .first_sample_bus_i(first_sample_bus_o),
        .second_sample_bus_i(second_sample_bus_o),
        .pair_o(pair), .count_o(cnt));

    always #10 clk_i = ~clk_i;
    initial begin
        #7;
        forever #80 sample_clk_i = ~sample_clk_i;
    end

    function automatic int mv_of(int i);
        return (i == 127) ? 350 : i * 4 - 256;
    endfunction : mv_of

    function automatic logic [7:0] code_of(int i);
        int h, s, v;
        h = full_scale_select_i ? int'(ADCD_HALF_HI) : int'(ADCD_HALF_LO);
        s = full_scale_select_i ? int'(ADCD_SCALE_HI) : int'(ADCD_SCALE_LO);
        v = ((mv_of(i) + h) * s) >>> 16;
        return (v > 255) ? 8'hFF : (v < 0) ? 8'h00 : 8'(v);
    endfunction : code_of

    task automatic complete_run;
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        r = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        if (k >= 20) begin
            failures++;
            complete_run();
        end
    endtask : wb

    task automatic falls(input int k);
        repeat (k) @(negedge sample_clk_i);
        @(posedge clk_i);
    endtask : falls

    task automatic count_until(input logic lvl, output int k);
        k = 0;
        while (calibration_running_o !== lvl && k < 40) begin
            falls(1);
            k++;
        end
        if (k >= 40) begin
            failures++;
            complete_run();
        end
    endtask : count_until

    task automatic do_reset(input logic s);
        @(posedge clk_i);
        rst_i <= 1;
        calibration_delay_select_i <= s;
        output_edge_select_i <= s;
        full_scale_select_i <= s;
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
    endtask : do_reset

    task automatic run_data(input logic o);
        falls(20);
        last = -1;
        oor_seen = 0;
        chk_on = 1;
        falls(140);
        chk_on = 0;
        chk(oor_seen, o);
    endtask : run_data

    always @(posedge clk_i) begin
        sc_d <= sample_clk_i;
        if (sample_clk_i && !sc_d) begin
            analog_in_i <= 16'(mv_of(idx));
            idx <= (idx + 1) % 128;
        end
        if (calibration_running_o === 1'b1) cal_seen <= 1;
    end

    always @(posedge clk_i) begin
        cnt_d <= cnt;
        if (chk_on && out_of_range_o === 1'b1) oor_seen = 1;
        if (chk_on && cnt != cnt_d) begin
            hit = -1;
            for (int i = 0; i < 128; i++) begin
                if (code_of(i) == pair[15:8]) begin
                    hit = i;
                end
            end
            chk(32'(hit >= 0), 1);
            chk(pair[7:0], code_of((hit + 1) % 128));
            if (last >= 0) chk(hit, (last + 2) % 128);
            // idx leads by one, capture trails the update by one sample
            chk((idx - hit + 128) % 128, ADCD_LAT_FIRST + 2);
            last = hit;
        end
    end

    initial begin
        do_reset(0);
        @(posedge clk_i);
        chk(32'({first_sample_bus_o, second_sample_bus_o, irq_o,
            output_data_clock_o, out_of_range_o, calibration_running_o}), 0);
        count_until(1, n);
        chk(32'(n inside {[4:6]}), 1);
        count_until(0, n);
        chk(32'(n inside {[6:8]}), 1);
        wb(0, ADCD_OFS_MASK, 0, q);
        chk(q, 32'(ADCD_MASK_RST));
        wb(1, 8'h40, 32'hFF, q);
        wb(0, 8'h40, 0, q);
        chk(q, 0);
        wb(1, ADCD_OFS_MASK, 32'h1, q);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1);
        wb(0, ADCD_OFS_STATUS, 0, q);
        chk(q[1:0], 2'h3);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 0);
        wb(0, ADCD_OFS_STATE, 0, q);
        chk(q[7:3], 5'h04);
        run_data(1);
        wb(0, ADCD_OFS_STATUS, 0, q);
        chk(q[3:2], 2'h3);
        calibration_request_i <= 0;
        falls(5);
        calibration_request_i <= 1;
        cal_seen = 0;
        falls(12);
        chk(cal_seen, 0);
        calibration_request_i <= 0;
        falls(11);
        calibration_request_i <= 1;
        falls(8);
        chk(cal_seen, 0);
        falls(4);
        chk(cal_seen, 1);
        count_until(0, n);
        wb(1, ADCD_OFS_CTRL, 32'h1, q);
        falls(1);
        chk(calibration_running_o, 1);
        count_until(0, n);
        power_down_pin_i <= 1;
        falls(2);
        c = cnt;
        falls(6);
        chk(cnt, c);
        power_down_pin_i <= 0;
        falls(6);
        chk(32'(cnt != c), 1);
        do_reset(1);
        count_until(1, n);
        chk(32'(n inside {[8:10]}), 1);
        count_until(0, n);
        chk(32'(n inside {[6:8]}), 1);
        wb(0, ADCD_OFS_STATE, 0, q);
        chk(q[7:3], 5'h05);
        run_data(0);
        complete_run();
    end
endmodule : tb
